// File: ssp_defs.svh
/*
  Named numbers for the shutdown program sequencer with power-on reset.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SSP_IDX_W 9
`define SSP_NREGS 128
`define SSP_CTRL_IDX 9'h06f
`define SSP_STAT_IDX 9'h070
`define SSP_BIAS_IDX 7'h04
`define SSP_BIAS_DEFAULT 16'h0018

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define SSP_START_BIT 8
`define SSP_ABORT_BIT 9
`define SSP_PIDX_W 7
`define SSP_BUSY_BIT 0
`define SSP_SHUTDOWN_CMD 16'h0120
`define SSP_SHUTDOWN_IDX 7'h20
`define SSP_LAST_IDX 7'h30

// ----------------------------------------------------------------
// delay codes and times
// ----------------------------------------------------------------
`define SSP_CLK_NS 50
`define SSP_DLY_C9 4'h9
`define SSP_DLY_CC 4'hc
`define SSP_DLY0_NS 562500
`define SSP_DLY9_NS 32500000
`define SSP_DLYC_NS 256500000
`define SSP_TPOR_NS 10600
`define SSP_CNT_W 23

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_SLVERR 2'b10
`define SSP_AXI_AW 12

`endif

// File: ssp_pkg.sv
/*
  Types shared by the sequencer design.
  Assumes ssp_defs.svh is on the include path.
*/
`include "ssp_defs.svh"

package ssp_pkg;

  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_EXEC = 2'b01,
    SSP_WAIT = 2'b10
  } ssp_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] width;
    logic [3:0] start;
    logic [7:0] data;
    logic [3:0] delay;
    logic end_of_program_flag;
  } ssp_entry_t;

endpackage : ssp_pkg

// File: ssp_sequencer.sv
/*
  Control write sequencer holding the default power-down program, the codec
  register file it edits, the power-on reset release logic and an AXI4-Lite
  slave. Assumes one 20 MHz clock, a synchronous active-low rst_n, and a
  por_n level from the analogue supply monitor, asynchronous to clock.
*/
`timescale 1ns/1ps
`include "ssp_defs.svh"

// How it works
// - writing 0120h to the control register runs the program from index 20h
// - whole power-down program takes about 297 ms with nominal clocking
// - entries 32,33 write 77h to 5Eh then 5Ah, short 0.5625 ms wait
// - entries 34,35 write 00h to 5Ah then 5Eh
// - entry 36 clears four servo enables at bit 0 of 43h
// - entry 37 clears charge pump enable, bit 0 of 62h
// - entry 38 clears the two converter enables at bit 2 of 12h
// - entry 39 clears the dsp clock enable, bit 1 of 16h
// - entries 40-42 clear two-bit fields of 0Eh, 0Fh, then 0Dh
// - entry 43 clears master bias enable, bit 0 of 04h
// - entry 44 loads 2 into the ramp rate field at bit 3 of 05h
// - entry 45 clears reference buffer enable, then waits 256.5 ms
// - entry 46 repeats that clear, then waits 32.5 ms
// - entry 47 writes 00h to the low byte of 05h
// - entry 48 clears bits 1:0 of 04h and ends the program
// - during power-on reset logic stays reset and bus writes are dropped
// - after release every register holds its default and writes work
// - power-on reset lasts at least 10.6 us after supplies are good
// - running flag is 1 while the program runs, 0 once done
module ssp_sequencer #(
  parameter int DLY0_CYC = `SSP_DLY0_NS / `SSP_CLK_NS,
  parameter int DLY9_CYC = `SSP_DLY9_NS / `SSP_CLK_NS,
  parameter int DLYC_CYC = `SSP_DLYC_NS / `SSP_CLK_NS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic [`SSP_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SSP_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sequencer_running_flag,
  output logic por_active
);
  import ssp_pkg::*;

  localparam int TPOR_CYC = (`SSP_TPOR_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // the power-down program; indices outside it end at once
  function automatic ssp_entry_t prog_entry(input logic [`SSP_PIDX_W-1:0] idx);
    ssp_entry_t e;
    e = '{addr: 8'hff, width: 4'h1, start: 4'h0, data: 8'h00, delay: 4'h0, end_of_program_flag: 1'b1};
    case (idx)
      7'h20: e = '{8'h5e, 4'h8, 4'h0, 8'h77, 4'h0, 1'b0};
      7'h21: e = '{8'h5a, 4'h8, 4'h0, 8'h77, 4'h0, 1'b0};
      7'h22: e = '{8'h5a, 4'h8, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h23: e = '{8'h5e, 4'h8, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h24: e = '{8'h43, 4'h4, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h25: e = '{8'h62, 4'h1, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h26: e = '{8'h12, 4'h2, 4'h2, 8'h00, 4'h0, 1'b0};
      7'h27: e = '{8'h16, 4'h1, 4'h1, 8'h00, 4'h0, 1'b0};
      7'h28: e = '{8'h0e, 4'h2, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h29: e = '{8'h0f, 4'h2, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h2a: e = '{8'h0d, 4'h2, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h2b: e = '{8'h04, 4'h1, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h2c: e = '{8'h05, 4'h2, 4'h3, 8'h02, 4'h0, 1'b0};
      7'h2d: e = '{8'h05, 4'h1, 4'h0, 8'h00, 4'hc, 1'b0};
      7'h2e: e = '{8'h05, 4'h1, 4'h0, 8'h00, 4'h9, 1'b0};
      7'h2f: e = '{8'h05, 4'h8, 4'h0, 8'h00, 4'h0, 1'b0};
      7'h30: e = '{8'h04, 4'h2, 4'h0, 8'h00, 4'h0, 1'b1};
      default: e = '{8'hff, 4'h1, 4'h0, 8'h00, 4'h0, 1'b1};
    endcase
    return e;
  endfunction : prog_entry

  // field update: only width bits from start change
  function automatic logic [15:0] merge_field(input logic [15:0] old, input ssp_entry_t e);
    logic [15:0] mask;
    mask = 16'((17'h00001 << e.width) - 17'h00001) << e.start;
    return (old & ~mask) | ((16'(e.data) << e.start) & mask);
  endfunction : merge_field

  function automatic logic [`SSP_CNT_W-1:0] delay_cycles(input logic [3:0] code);
    logic [`SSP_CNT_W-1:0] c;
    case (code)
      `SSP_DLY_CC: c = `SSP_CNT_W'(DLYC_CYC);
      `SSP_DLY_C9: c = `SSP_CNT_W'(DLY9_CYC);
      default: c = `SSP_CNT_W'(DLY0_CYC);
    endcase
    return c;
  endfunction : delay_cycles

  function automatic logic [15:0] reg_default(input int i);
    return (i == int'(`SSP_BIAS_IDX)) ? `SSP_BIAS_DEFAULT : 16'h0000;
  endfunction : reg_default

  // ----------------------------------------------------------------
  // power-on reset release
  // ----------------------------------------------------------------
  logic por_s1_reg, por_s2_reg, por_s3_reg, por_lvl_reg;
  logic [7:0] por_cnt_reg;
  logic live_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      por_s1_reg <= 1'b0;
      por_s2_reg <= 1'b0;
      por_s3_reg <= 1'b0;
      por_lvl_reg <= 1'b0;
    end else begin
      por_s1_reg <= por_n;
      por_s2_reg <= por_s1_reg;
      por_s3_reg <= por_s2_reg;
      if (por_s2_reg == por_s3_reg) begin
        por_lvl_reg <= por_s3_reg;
      end
    end
  end

  // a supply that rises at once still gets the whole minimum period
  always_ff @(posedge clock) begin
    if (!rst_n || !por_lvl_reg) begin
      por_cnt_reg <= 8'h00;
      live_reg <= 1'b0;
    end else if (por_cnt_reg != 8'(TPOR_CYC)) begin
      por_cnt_reg <= por_cnt_reg + 8'h01;
    end else begin
      live_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      por_active <= 1'b1;
    end else begin
      por_active <= ~live_reg;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [`SSP_IDX_W-1:0] aw_idx_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg, w_held_reg;
  logic do_write;
  logic [`SSP_IDX_W-1:0] ar_idx;

  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign ar_idx = s_axi_araddr[`SSP_IDX_W+1:2];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx_reg <= s_axi_awaddr[`SSP_IDX_W+1:2];
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        // dropped writes still answer so a master never hangs
        s_axi_bresp <= (!live_reg || aw_idx_reg > `SSP_STAT_IDX) ? `SSP_RESP_SLVERR : `SSP_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file and sequencer
  // ----------------------------------------------------------------
  logic [15:0] regs [`SSP_NREGS];
  logic [`SSP_PIDX_W-1:0] ctrl_idx_reg;
  ssp_state_t state_reg;
  logic [`SSP_PIDX_W-1:0] pc_reg;
  logic [`SSP_CNT_W-1:0] wait_reg;
  ssp_entry_t cur;
  logic sw_ok, sw_start, sw_abort;
  logic [15:0] sw_val;

  assign cur = prog_entry(pc_reg);
  assign sw_ok = do_write && live_reg;
  assign sw_val = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00, wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};
  assign sw_start = sw_ok && aw_idx_reg == `SSP_CTRL_IDX && wstrb_reg[1] && wdata_reg[`SSP_START_BIT];
  assign sw_abort = sw_ok && aw_idx_reg == `SSP_CTRL_IDX && wstrb_reg[1] && wdata_reg[`SSP_ABORT_BIT];

  always_ff @(posedge clock) begin
    if (!rst_n || !live_reg) begin
      for (int i = 0; i < `SSP_NREGS; i++) begin
        regs[i] <= reg_default(i);
      end
    end else begin
      if (sw_ok && aw_idx_reg < `SSP_STAT_IDX && aw_idx_reg != `SSP_CTRL_IDX) begin
        regs[aw_idx_reg[6:0]] <= sw_val;
      end
      // the program's own edit wins a same-cycle clash on one register
      if (state_reg == SSP_EXEC && !cur.addr[7]) begin
        regs[cur.addr[6:0]] <= merge_field(regs[cur.addr[6:0]], cur);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !live_reg) begin
      ctrl_idx_reg <= '0;
    end else if (sw_ok && aw_idx_reg == `SSP_CTRL_IDX && wstrb_reg[0]) begin
      ctrl_idx_reg <= wdata_reg[`SSP_PIDX_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !live_reg) begin
      state_reg <= SSP_IDLE;
      pc_reg <= '0;
      wait_reg <= '0;
    end else if (sw_abort) begin
      state_reg <= SSP_IDLE;
    end else begin
      case (state_reg)
        SSP_IDLE: begin
          if (sw_start) begin
            pc_reg <= wstrb_reg[0] ? wdata_reg[`SSP_PIDX_W-1:0] : ctrl_idx_reg;
            state_reg <= SSP_EXEC;
          end
        end
        SSP_EXEC: begin
          if (cur.end_of_program_flag) begin
            state_reg <= SSP_IDLE;
          end else begin
            wait_reg <= delay_cycles(cur.delay);
            state_reg <= SSP_WAIT;
          end
        end
        SSP_WAIT: begin
          if (wait_reg <= `SSP_CNT_W'(1)) begin
            pc_reg <= pc_reg + `SSP_PIDX_W'(1);
            state_reg <= SSP_EXEC;
          end else begin
            wait_reg <= wait_reg - `SSP_CNT_W'(1);
          end
        end
        default: state_reg <= SSP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sequencer_running_flag <= 1'b0;
    end else begin
      sequencer_running_flag <= live_reg && (state_reg != SSP_IDLE || sw_start);
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SSP_RESP_OKAY;
      if (ar_idx == `SSP_STAT_IDX) begin
        s_axi_rdata <= {31'h0000_0000, sequencer_running_flag};
      end else if (ar_idx == `SSP_CTRL_IDX) begin
        s_axi_rdata <= {25'h000_0000, ctrl_idx_reg};
      end else if (ar_idx < `SSP_STAT_IDX) begin
        s_axi_rdata <= {16'h0000, regs[ar_idx[6:0]]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `SSP_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence start_seen;
    live_reg && state_reg == SSP_IDLE && sw_start && !sw_abort;
  endsequence

  AST_START_SHUTDOWN: assert property (@(posedge clock) disable iff (!rst_n)
    (start_seen and (wstrb_reg[0] && wdata_reg[15:0] == `SSP_SHUTDOWN_CMD)) |=> pc_reg == `SSP_SHUTDOWN_IDX)
    else $error("shutdown did not start at index 20h");

  AST_BUSY_RISES: assert property (@(posedge clock) disable iff (!rst_n)
    start_seen |=> sequencer_running_flag ##1 sequencer_running_flag)
    else $error("running flag missing after start");

  AST_SHORT_WAIT: assert property (@(posedge clock) disable iff (!rst_n || sw_abort)
    live_reg && state_reg == SSP_EXEC && !cur.end_of_program_flag && cur.delay == 4'h0 |=> wait_reg == `SSP_CNT_W'(DLY0_CYC))
    else $error("short delay count wrong");

  AST_LONG_WAIT: assert property (@(posedge clock) disable iff (!rst_n || sw_abort)
    live_reg && state_reg == SSP_EXEC && pc_reg == 7'h2d |=> wait_reg == `SSP_CNT_W'(DLYC_CYC))
    else $error("256.5 ms delay count wrong");

  AST_MID_WAIT: assert property (@(posedge clock) disable iff (!rst_n || sw_abort)
    live_reg && state_reg == SSP_EXEC && pc_reg == 7'h2e |=> wait_reg == `SSP_CNT_W'(DLY9_CYC))
    else $error("32.5 ms delay count wrong");

  AST_END_STOPS: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == SSP_EXEC && pc_reg == `SSP_LAST_IDX && live_reg && !sw_abort
      |=> state_reg == SSP_IDLE ##1 !sequencer_running_flag)
    else $error("program did not end after entry 48");

  AST_SERVO_CLEARED: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == SSP_EXEC && pc_reg == 7'h24 && live_reg && !sw_abort |=> regs[7'h43][3:0] == 4'h0)
    else $error("servo enables not cleared");

  AST_RAMP_LOADED: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == SSP_EXEC && pc_reg == 7'h2c && live_reg && !sw_abort |=> regs[7'h05][4:3] == 2'b10)
    else $error("ramp rate not loaded");

  AST_POR_DROPS_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    do_write && !live_reg |=> s_axi_bresp == `SSP_RESP_SLVERR && !sequencer_running_flag)
    else $error("write accepted during power-on reset");

  AST_POR_MIN: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(live_reg) |-> $past(por_cnt_reg) == 8'(TPOR_CYC) && por_lvl_reg)
    else $error("power-on reset released too early");

  AST_DEFAULT_AT_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(live_reg) |-> regs[`SSP_BIAS_IDX] == `SSP_BIAS_DEFAULT && state_reg == SSP_IDLE)
    else $error("registers not at default on release");

endmodule : ssp_sequencer

// File: tb_top.sv
/*
  Self-checking bench for the shutdown program sequencer: power-on reset
  hold, dropped writes, register defaults, the shutdown edits and their timing.
  Assumes ssp_defs.svh and ssp_pkg are compiled first; delays are shortened.
*/
`timescale 1ns/1ps
`include "ssp_defs.svh"

module tb_top;
  import ssp_pkg::*;

  // ------------------------------------------------------------
  // clock, reset and stimulus signals
  // ------------------------------------------------------------
  localparam int D0 = 4;
  localparam int D9 = 20;
  localparam int DC = 40;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic [11:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic sequencer_running_flag;
  logic por_active;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  initial begin
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
  end

  ssp_sequencer #(.DLY0_CYC(D0), .DLY9_CYC(D9), .DLYC_CYC(DC)) ssp_sequencer_i (
    .clock(clock), .rst_n(rst_n), .por_n(por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sequencer_running_flag(sequencer_running_flag), .por_active(por_active)
  );

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic bad(input string m);
    n_errors++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) bad($sformatf("%s got %h want %h", what, got, exp));
  endtask : chk_val

  task automatic chk_span(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) bad($sformatf("%s took %0d cycles, want %0d..%0d", what, got, lo, hi));
  endtask : chk_span

  // ------------------------------------------------------------
  // bus master: handshakes judged from values settled before each edge
  // ------------------------------------------------------------
  task automatic axi_write(input logic [8:0] idx, input logic [15:0] val, output logic [1:0] resp);
    bit aw_hs;
    bit w_hs;
    bit b_hs;
    @(posedge clock);
    awaddr <= {1'b0, idx, 2'b00};
    wdata <= {16'h0000, val};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      #1;
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid === 1'b1;
      resp = bresp;
      @(posedge clock);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        return;
      end
    end
    bad("write answer never came");
    conclude();
  endtask : axi_write

  task automatic axi_read(input logic [8:0] idx, output logic [31:0] data, output logic [1:0] resp);
    bit ar_hs;
    bit r_hs;
    @(posedge clock);
    araddr <= {1'b0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      #1;
      ar_hs = arvalid && arready;
      r_hs = rvalid === 1'b1;
      data = rdata;
      resp = rresp;
      @(posedge clock);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        return;
      end
    end
    bad("read answer never came");
    conclude();
  endtask : axi_read

  // sel 0 waits on por_active, sel 1 on the running flag
  task automatic wait_low(input bit sel, input int lim);
    for (int n = 0; n < lim; n++) begin
      #1;
      if ((sel ? sequencer_running_flag : por_active) === 1'b0) return;
      @(posedge clock);
    end
    bad("level never dropped");
    conclude();
  endtask : wait_low

  // ------------------------------------------------------------
  // expected values: the shutdown table and its field edits
  // ------------------------------------------------------------
  function automatic ssp_entry_t ent(input int i);
    ssp_entry_t e;
    e = '0;
    case (i)
      0: e = '{8'h5e, 4'd8, 4'd0, 8'h77, 4'h0, 1'b0};
      1: e = '{8'h5a, 4'd8, 4'd0, 8'h77, 4'h0, 1'b0};
      2: e = '{8'h5a, 4'd8, 4'd0, 8'h00, 4'h0, 1'b0};
      3: e = '{8'h5e, 4'd8, 4'd0, 8'h00, 4'h0, 1'b0};
      4: e = '{8'h43, 4'd4, 4'd0, 8'h00, 4'h0, 1'b0};
      5: e = '{8'h62, 4'd1, 4'd0, 8'h00, 4'h0, 1'b0};
      6: e = '{8'h12, 4'd2, 4'd2, 8'h00, 4'h0, 1'b0};
      7: e = '{8'h16, 4'd1, 4'd1, 8'h00, 4'h0, 1'b0};
      8: e = '{8'h0e, 4'd2, 4'd0, 8'h00, 4'h0, 1'b0};
      9: e = '{8'h0f, 4'd2, 4'd0, 8'h00, 4'h0, 1'b0};
      10: e = '{8'h0d, 4'd2, 4'd0, 8'h00, 4'h0, 1'b0};
      11: e = '{8'h04, 4'd1, 4'd0, 8'h00, 4'h0, 1'b0};
      12: e = '{8'h05, 4'd2, 4'd3, 8'h02, 4'h0, 1'b0};
      13: e = '{8'h05, 4'd1, 4'd0, 8'h00, 4'hc, 1'b0};
      14: e = '{8'h05, 4'd1, 4'd0, 8'h00, 4'h9, 1'b0};
      15: e = '{8'h05, 4'd8, 4'd0, 8'h00, 4'h0, 1'b0};
      default: e = '{8'h04, 4'd2, 4'd0, 8'h00, 4'h0, 1'b1};
    endcase
    return e;
  endfunction : ent

  function automatic logic [15:0] expect_reg(input logic [7:0] a, input logic [15:0] v);
    ssp_entry_t e;
    logic [15:0] m;
    for (int i = 0; i < 17; i++) begin
      e = ent(i);
      if (e.addr == a) begin
        m = ((16'h0001 << e.width) - 16'h0001) << e.start;
        v = (v & ~m) | ((16'(e.data) << e.start) & m);
      end
    end
    return v;
  endfunction : expect_reg

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  logic [7:0] regs [11] = '{8'h5e, 8'h5a, 8'h43, 8'h62, 8'h12, 8'h16, 8'h0e, 8'h0f, 8'h0d, 8'h04, 8'h05};
  logic [15:0] pre [11];
  logic [31:0] d;
  logic [1:0] r;
  int t0;
  // short waits: entries 32..44 and 47; the last entry has none
  int span = 14 * D0 + DC + D9;

  initial begin
    void'($urandom(54386));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t0 = cyc;
    axi_write(9'h004, 16'h00ff, r);
    chk_val(r, `SSP_RESP_SLVERR, "write during reset hold");
    axi_read(9'h004, d, r);
    chk_val(d, `SSP_BIAS_DEFAULT, "bias default in reset hold");
    wait_low(1'b0, 400);
    chk_span(cyc - t0, 212, 230, "reset hold");
    axi_read(9'h004, d, r);
    chk_val(d, `SSP_BIAS_DEFAULT, "dropped write left no trace");
    axi_read(9'h071, d, r);
    chk_val(r, `SSP_RESP_SLVERR, "unmapped read");
    // random starting contents, as the start-up program would leave them
    foreach (regs[k]) begin
      pre[k] = 16'($urandom());
      axi_write({1'b0, regs[k]}, pre[k], r);
      chk_val(r, `SSP_RESP_OKAY, "accepted write");
    end
    axi_write(`SSP_CTRL_IDX, `SSP_SHUTDOWN_CMD, r);
    t0 = cyc;
    axi_read(`SSP_STAT_IDX, d, r);
    chk_val(d[0], 1'b1, "running flag in status");
    wait_low(1'b1, 2000);
    chk_span(cyc - t0, span, span + 17 * 8, "shutdown program");
    axi_read(`SSP_STAT_IDX, d, r);
    chk_val(d[0], 1'b0, "running flag after end");
    axi_read(`SSP_CTRL_IDX, d, r);
    chk_val(d, 32'h00000020, "stored start index");
    foreach (regs[k]) begin
      axi_read({1'b0, regs[k]}, d, r);
      chk_val(d, {16'h0000, expect_reg(regs[k], pre[k])}, "edited register");
    end
    // supply loss in mid-program: all back to default, program stopped
    axi_write(9'h05a, 16'ha5c3, r);
    // abort in mid-program drops straight back to idle
    axi_write(`SSP_CTRL_IDX, `SSP_SHUTDOWN_CMD, r);
    axi_write(`SSP_CTRL_IDX, 16'h0200, r);
    axi_read(`SSP_STAT_IDX, d, r);
    chk_val(d[0], 1'b0, "running flag after abort");
    axi_write(`SSP_CTRL_IDX, `SSP_SHUTDOWN_CMD, r);
    repeat (3) @(posedge clock);
    por_n <= 1'b0;
    repeat (6) @(posedge clock);
    por_n <= 1'b1;
    #1;
    chk_val(sequencer_running_flag, 1'b0, "flag after supply loss");
    chk_val(por_active, 1'b1, "reset held after supply loss");
    wait_low(1'b0, 400);
    axi_read(9'h05a, d, r);
    chk_val(d, 32'h00000000, "default after supply loss");
    axi_read(9'h004, d, r);
    chk_val(d, `SSP_BIAS_DEFAULT, "bias default after supply loss");
    conclude();
  end

endmodule : tb_top
